// ==== design/cepg_top.v ====
// Camera exposure pulse generator channel with its APB register slave.
// Assumes pclk at 50 MHz, a free-running crystal on xtal_clk_in, and that the
// master channel's raw_pulse_out feeds master_pulse_in on the same pclk.
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "cepg_regs.vh"

// Function
// - Timebase is free-running crystal, acquisition independent.
// - Divide select picks base clock or /128.
// - Base 7.3728 MHz, reduced 57.6000 KHz.
// - Period and width are 28-bit timebase counts.
// - Restart write clears counter, starts fresh cycle.
// - Invert bit flips waveform to active low.
// - Free-run uses period and width; single-pulse width.
// - Source select: encoder when 1, trigger 0.
// - Free-run: assert after zero, drop at width, wrap.
// - Single-pulse: wait event, pulse width, return zero.
// - Follow-master bit copies master channel timing.
// - Camera-control route code 3 carries waveform.
// - General output route code 6, many outputs.
// - First register: period, single-pulse, source select.
// - Second: invert, divide; third: width, restart, follow.
module cepg_top #(
   parameter N_CC = 4,
   parameter N_GP = 4
) (
   input wire pclk,
   input wire presetn,
   input wire [11:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output reg [31:0] prdata,
   output wire pready,
   output reg pslverr,
   input wire xtal_clk_in,
   input wire trigger_in,
   input wire encoder_in,
   input wire master_pulse_in,
   output wire raw_pulse_out,
   output reg [N_CC-1:0] cc_out,
   output reg [N_GP-1:0] gp_out
);
   // Control registers.
   reg [31:0] rate_mode_q;
   reg [31:0] pol_tb_q;
   reg [31:0] width_ctl_q;
   reg [31:0] route_q;

   // Generator state.
   reg [`CEPG_CNT_W-1:0] cnt_q;
   reg [`CEPG_CNT_W-1:0] cnt_d;
   reg pend_q;
   reg pend_d;
   reg raw_q;
   reg [N_CC-1:0] cc_d;
   reg [N_GP-1:0] gp_d;

   // Bus decode.
   wire setup_rd;
   wire access_wr;
   wire restart;
   wire hit;

   // Counter clear sources.
   wire mode_flip;
   wire cnt_clr;

   // Field views.
   wire [`CEPG_CNT_W-1:0] period_value;
   wire [`CEPG_CNT_W-1:0] pulse_width_value;
   wire single_pulse_mode;
   wire pulse_source_select;
   wire polarity_invert;
   wire timebase_divide_select;
   wire follow_master;

   // Timebase and events.
   wire base_tick;
   wire tick;
   wire trig_rise;
   wire enc_rise;
   wire event_rise;
   wire own_pulse;
   wire wave;
   wire busy;
   wire [`CEPG_CNT_W:0] cnt_inc;

   // Merges write data into a register under byte strobes and a bit mask.
   function [31:0] apply_wr;
      input [31:0] old_val;
      input [31:0] new_val;
      input [3:0] strb;
      input [31:0] mask;
      integer i;
      reg [31:0] tmp;
      begin
         tmp = old_val;
         for (i = 0; i < 4; i = i + 1) begin
            if (strb[i]) begin
               tmp[i*8 +: 8] = new_val[i*8 +: 8];
            end
         end
         apply_wr = tmp & mask;
      end
   endfunction

   // True when a route field holds the given selector code.
   function route_is;
      input [31:0] route;
      input integer idx;
      input [`CEPG_ROUTE_FLD_W-1:0] code;
      begin
         route_is = (route[idx*`CEPG_ROUTE_FLD_W +: `CEPG_ROUTE_FLD_W] == code);
      end
   endfunction

   // True for any decoded register offset.
   function addr_hit;
      input [11:0] addr;
      begin
         addr_hit = (addr == `CEPG_OFS_RATE_MODE) || (addr == `CEPG_OFS_POL_TB) ||
                    (addr == `CEPG_OFS_WIDTH_CTL) || (addr == `CEPG_OFS_STATUS) ||
                    (addr == `CEPG_OFS_ROUTE);
      end
   endfunction

   // The slave never waits: every access phase completes in one cycle.
   assign pready = 1'b1;
   assign setup_rd = psel & ~penable & ~pwrite;
   assign access_wr = psel & penable & pwrite;
   assign hit = addr_hit(paddr);

   assign period_value = rate_mode_q[`CEPG_CNT_W-1:0];
   assign single_pulse_mode = rate_mode_q[`CEPG_BIT_SINGLE_PULSE];
   assign pulse_source_select = rate_mode_q[`CEPG_BIT_SOURCE_SEL];
   assign polarity_invert = pol_tb_q[`CEPG_BIT_POL_INVERT];
   assign timebase_divide_select = pol_tb_q[`CEPG_BIT_DIVIDE_SEL];
   assign pulse_width_value = width_ctl_q[`CEPG_CNT_W-1:0];
   assign follow_master = width_ctl_q[`CEPG_BIT_FOLLOW];

   // The restart bit is never stored; a write of 1 acts once and reads back 0.
   assign restart = access_wr & (paddr == `CEPG_OFS_WIDTH_CTL) & pstrb[3] &
                    pwdata[`CEPG_BIT_RESTART];

   // A write that flips the single-pulse mode bit also clears the counter and
   // the pending event, so a cycle left over from the old mode can neither
   // stretch into a pulse nor wait for an event that never comes.
   assign mode_flip = access_wr & (paddr == `CEPG_OFS_RATE_MODE) & pstrb[3] &
                      (pwdata[`CEPG_BIT_SINGLE_PULSE] != single_pulse_mode);
   assign cnt_clr = restart | mode_flip;

   // Register writes take effect at the access phase.
   // Writes to the status register or to unmapped offsets are ignored.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rate_mode_q <= `CEPG_RST_RATE_MODE;
         pol_tb_q <= `CEPG_RST_POL_TB;
         width_ctl_q <= `CEPG_RST_WIDTH_CTL;
         route_q <= `CEPG_RST_ROUTE;
      end else if (access_wr) begin
         case (paddr)
            `CEPG_OFS_RATE_MODE: begin
               rate_mode_q <= apply_wr(rate_mode_q, pwdata, pstrb, `CEPG_MASK_RATE_MODE);
            end
            `CEPG_OFS_POL_TB: begin
               pol_tb_q <= apply_wr(pol_tb_q, pwdata, pstrb, `CEPG_MASK_POL_TB);
            end
            `CEPG_OFS_WIDTH_CTL: begin
               width_ctl_q <= apply_wr(width_ctl_q, pwdata, pstrb, `CEPG_MASK_WIDTH_CTL);
            end
            `CEPG_OFS_ROUTE: begin
               route_q <= apply_wr(route_q, pwdata, pstrb, `CEPG_MASK_ROUTE);
            end
            default: begin
               route_q <= route_q;
            end
         endcase
      end
   end

   // Read data and error are loaded in the setup cycle so that both come
   // from flops during the zero-wait access phase.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (psel & ~penable) begin
         pslverr <= ~hit;
         prdata <= 32'h00000000;
         if (setup_rd) begin
            case (paddr)
               `CEPG_OFS_RATE_MODE: begin
                  prdata <= rate_mode_q;
               end
               `CEPG_OFS_POL_TB: begin
                  prdata <= pol_tb_q;
               end
               `CEPG_OFS_WIDTH_CTL: begin
                  prdata <= width_ctl_q;
               end
               `CEPG_OFS_STATUS: begin
                  prdata <= {1'b0, busy, pend_q, raw_q, cnt_q};
               end
               `CEPG_OFS_ROUTE: begin
                  prdata <= route_q;
               end
               default: begin
                  prdata <= 32'h00000000;
               end
            endcase
         end
      end
   end

   // The crystal is sampled on pclk; each of its rising edges is one base tick,
   // so the timebase never depends on camera or acquisition state.
   cepg_sync_edge u_xtal_sync (
      .clk(pclk),
      .rst_n(presetn),
      .din(xtal_clk_in),
      .level(),
      .rise(base_tick)
   );

   // In divided mode the tick is every 128th crystal edge; the prescaler phase is
   // not reset by a mode change, so the first divided tick may come early.
   cepg_tick_div u_tick_div (
      .clk(pclk),
      .rst_n(presetn),
      .base_tick(base_tick),
      .div_sel(timebase_divide_select),
      .tick(tick)
   );

   // Trigger and encoder pins are event sources for single-pulse mode only; both
   // are synchronised even when unused so that a source switch sees settled edges.
   cepg_sync_edge u_trig_sync (
      .clk(pclk),
      .rst_n(presetn),
      .din(trigger_in),
      .level(),
      .rise(trig_rise)
   );

   cepg_sync_edge u_enc_sync (
      .clk(pclk),
      .rst_n(presetn),
      .din(encoder_in),
      .level(),
      .rise(enc_rise)
   );

   // Only the selected source can start a pulse; the other pin is ignored.
   assign event_rise = pulse_source_select ? enc_rise : trig_rise;
   assign busy = (cnt_q != {`CEPG_CNT_W{1'b0}});
   assign cnt_inc = {1'b0, cnt_q} + 1'b1;

   // Event latch for single-pulse mode; events during a pulse are dropped.
   // A pending event is consumed by the tick that loads count one.
   always @* begin
      pend_d = pend_q;
      if (cnt_clr | ~single_pulse_mode) begin
         pend_d = 1'b0;
      end else if (tick & ~busy & pend_q) begin
         pend_d = 1'b0;
      end else if (event_rise & ~busy) begin
         pend_d = 1'b1;
      end
   end

   // Counter: advances once per timebase tick.
   always @* begin
      cnt_d = cnt_q;
      if (cnt_clr) begin
         cnt_d = {`CEPG_CNT_W{1'b0}};
      end else if (tick) begin
         if (single_pulse_mode) begin
            if (!busy) begin
               cnt_d = pend_q ? {{(`CEPG_CNT_W-1){1'b0}}, 1'b1} : cnt_q;
            end else if (cnt_inc >= {1'b0, pulse_width_value}) begin
               cnt_d = {`CEPG_CNT_W{1'b0}};
            end else begin
               cnt_d = cnt_inc[`CEPG_CNT_W-1:0];
            end
         end else if (cnt_inc >= {1'b0, period_value}) begin
            cnt_d = {`CEPG_CNT_W{1'b0}};
         end else begin
            cnt_d = cnt_inc[`CEPG_CNT_W-1:0];
         end
      end
   end

   // Active from count 1 until the count reaches the width; period is unused
   // in single-pulse mode because the counter returns to zero at the width.
   assign own_pulse = busy & (single_pulse_mode | (cnt_q < pulse_width_value));

   // A follower copies the master's uninverted pulse one pclk late and applies its
   // own polarity, so master and follower lines may be set to opposite senses.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= {`CEPG_CNT_W{1'b0}};
         pend_q <= 1'b0;
         raw_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         pend_q <= pend_d;
         raw_q <= follow_master ? master_pulse_in : own_pulse;
      end
   end

   assign raw_pulse_out = raw_q;
   assign wave = raw_q ^ polarity_invert;

   // Output routing; unselected outputs idle low.
   // Camera line i takes route bits 4i+3..4i and general output i takes route bits
   // 4i+19..4i+16; codes other than the waveform code leave the pin low.
   always @* begin : route_blk
      integer k;
      cc_d = {N_CC{1'b0}};
      gp_d = {N_GP{1'b0}};
      for (k = 0; k < N_CC; k = k + 1) begin
         cc_d[k] = route_is(route_q, k, `CEPG_ROUTE_CC_WAVE) & wave;
      end
      for (k = 0; k < N_GP; k = k + 1) begin
         gp_d[k] = route_is(route_q, k + `CEPG_ROUTE_GP_BASE / `CEPG_ROUTE_FLD_W,
                            `CEPG_ROUTE_GP_WAVE) & wave;
      end
   end

   // Outputs are registered so that the pins never see decoder glitches when the
   // route register is rewritten.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cc_out <= {N_CC{1'b0}};
         gp_out <= {N_GP{1'b0}};
      end else begin
         cc_out <= cc_d;
         gp_out <= gp_d;
      end
   end
endmodule // cepg_top

// ==== design/cepg_regs.vh ====
// Register map, field positions, reset values and timebase figures of the
// camera exposure pulse generator. Included by the top and tick divider design files and the bench checker.
`ifndef CEPG_REGS_VH
`define CEPG_REGS_VH

// Byte offsets on the APB register bus.
`define CEPG_OFS_RATE_MODE 12'h000
`define CEPG_OFS_POL_TB 12'h004
`define CEPG_OFS_WIDTH_CTL 12'h008
`define CEPG_OFS_STATUS 12'h00C
`define CEPG_OFS_ROUTE 12'h010

// Field positions.
`define CEPG_CNT_W 28
`define CEPG_BIT_SINGLE_PULSE 30
`define CEPG_BIT_SOURCE_SEL 31
`define CEPG_BIT_POL_INVERT 30
`define CEPG_BIT_DIVIDE_SEL 31
`define CEPG_BIT_RESTART 30
`define CEPG_BIT_FOLLOW 31
`define CEPG_ROUTE_FLD_W 4
`define CEPG_ROUTE_GP_BASE 16

// Writable bits of each control register; the rest read as zero.
`define CEPG_MASK_RATE_MODE 32'hCFFFFFFF
`define CEPG_MASK_POL_TB 32'hC0000000
`define CEPG_MASK_WIDTH_CTL 32'h8FFFFFFF
`define CEPG_MASK_ROUTE 32'hFFFFFFFF

// Reset values.
`define CEPG_RST_RATE_MODE 32'h00000000
`define CEPG_RST_POL_TB 32'h00000000
`define CEPG_RST_WIDTH_CTL 32'h00000000
`define CEPG_RST_ROUTE 32'h00000000

// Route selector codes that pick the generator waveform.
`define CEPG_ROUTE_CC_WAVE 4'h3
`define CEPG_ROUTE_GP_WAVE 4'h6

// Timebase: undivided and reduced rates in Hz, and their ratio.
`define CEPG_BASE_HZ 7372800
`define CEPG_REDUCED_HZ 57600
`define CEPG_DIV_RATIO (`CEPG_BASE_HZ / `CEPG_REDUCED_HZ)
`define CEPG_DIV_W 7

`endif

// ==== design/cepg_sync_edge.v ====
// Two-flop synchroniser with rising-edge detection for one pin input.
// Assumes the pin is asynchronous to clk and held at least two clk periods per level.
`timescale 1ns/1ps

module cepg_sync_edge (
   input wire clk,
   input wire rst_n,
   input wire din,
   output wire level,
   output wire rise
);
   reg meta_q;
   reg sync_q;
   reg prev_q;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         meta_q <= din;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign level = sync_q;
   assign rise = sync_q & ~prev_q;
endmodule // cepg_sync_edge

// ==== design/cepg_tick_div.v ====
// Timebase tick selector: passes the base tick or every Nth base tick.
// Assumes base_tick is a one-cycle pulse on clk, one per crystal period.
`timescale 1ns/1ps
`include "cepg_regs.vh"

module cepg_tick_div (
   input wire clk,
   input wire rst_n,
   input wire base_tick,
   input wire div_sel,
   output wire tick
);
   localparam [31:0] LAST = `CEPG_DIV_RATIO - 1;

   reg [`CEPG_DIV_W-1:0] pre_q;
   wire wrap;

   assign wrap = (pre_q == LAST[`CEPG_DIV_W-1:0]);

   // The prescaler runs free so that switching ratio never stalls the timebase.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_q <= {`CEPG_DIV_W{1'b0}};
      end else if (base_tick) begin
         pre_q <= wrap ? {`CEPG_DIV_W{1'b0}} : pre_q + 1'b1;
      end
   end

   assign tick = base_tick & (~div_sel | wrap);
endmodule // cepg_tick_div

// ==== bench/cepg_props.sv ====
// Port checker for one pulse generator channel.
// Assumes software writes whole words with all byte strobes set.
`timescale 1ns/1ps
`include "cepg_regs.vh"
module cepg_props #(
   parameter N_CC = 4,
   parameter N_GP = 4
) (
   input wire pclk,
   input wire presetn,
   input wire [11:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pslverr,
   input wire trigger_in,
   input wire encoder_in,
   input wire master_pulse_in,
   input wire raw_pulse_out,
   input wire [N_CC-1:0] cc_out,
   input wire [N_GP-1:0] gp_out
);
   reg [31:0] rm_q, pt_q, wf_q, rt_q;
   reg [11:0] ev_q;
   wire wr = psel && penable && pwrite;
   wire rd = psel && penable && !pwrite;
   wire ev = rm_q[31] ? encoder_in : trigger_in;
   // Shadow registers, and cycles since the selected event pin last rose.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rm_q <= 32'h0;
         pt_q <= 32'h0;
         wf_q <= 32'h0;
         rt_q <= 32'h0;
         ev_q <= 12'hFFF;
      end else begin
         if (wr && paddr == 12'h000) rm_q <= pwdata;
         if (wr && paddr == 12'h004) pt_q <= pwdata;
         if (wr && paddr == 12'h008) wf_q <= pwdata;
         if (wr && paddr == 12'h010) rt_q <= pwdata;
         if ($rose(ev)) ev_q <= 12'h000;
         else if (ev_q != 12'hFFF) ev_q <= ev_q + 12'h001;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_cc_wave;
      $stable(rt_q) && $stable(pt_q) |->
         cc_out[0] == (rt_q[3:0] == 4'h3 && ($past(raw_pulse_out) ^ pt_q[30]));
   endproperty
   a_cc_wave: assert property (p_cc_wave) else $error("camera line wrong");
   property p_gp_wave;
      $stable(rt_q) && $stable(pt_q) |->
         gp_out[0] == (rt_q[19:16] == 4'h6 && ($past(raw_pulse_out) ^ pt_q[30]));
   endproperty
   a_gp_wave: assert property (p_gp_wave) else $error("general out wrong");
   property p_follow;
      wf_q[31] && $rose(master_pulse_in) |-> ##[1:2] raw_pulse_out;
   endproperty
   a_follow: assert property (p_follow) else $error("master not followed");
   property p_rd_rate;
      rd && paddr == 12'h000 |-> prdata == (rm_q & `CEPG_MASK_RATE_MODE);
   endproperty
   a_rd_rate: assert property (p_rd_rate) else $error("rate readback");
   property p_rd_pol;
      rd && paddr == 12'h004 |-> prdata == (pt_q & `CEPG_MASK_POL_TB);
   endproperty
   a_rd_pol: assert property (p_rd_pol) else $error("polarity readback");
   property p_rd_wf;
      rd && paddr == 12'h008 |-> prdata == (wf_q & `CEPG_MASK_WIDTH_CTL);
   endproperty
   a_rd_wf: assert property (p_rd_wf) else $error("width readback");
   property p_restart;
      wr && paddr == 12'h008 && pwdata[30] && !pwdata[31] |-> ##[1:2] !raw_pulse_out;
   endproperty
   a_restart: assert property (p_restart) else $error("restart kept pulse");
   property p_single;
      rm_q[30] && !wf_q[31] && $rose(raw_pulse_out) |-> ev_q <= 12'd1000;
   endproperty
   a_single: assert property (p_single) else $error("pulse without event");
   c_single: cover property (rm_q[30] && $rose(raw_pulse_out));
   c_err: cover property (pslverr);
   c_follow: cover property (wf_q[31] && raw_pulse_out);
endmodule // cepg_props
bind cepg_top cepg_props #(.N_CC(N_CC), .N_GP(N_GP)) i_cepg_props (
   .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
   .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
   .trigger_in(trigger_in), .encoder_in(encoder_in), .master_pulse_in(master_pulse_in),
   .raw_pulse_out(raw_pulse_out), .cc_out(cc_out), .gp_out(gp_out)
);

// ==== bench/cepg_cam_model.sv ====
// Camera exposure input: times the pulses that arrive on its control line.
// Assumes the line is a generator camera-control output.
`timescale 1ns/1ps
module cepg_cam_model (
   input wire line_in,
   output int n_rise,
   output realtime t_hi,
   output realtime t_lo,
   output realtime t_per
);
   realtime r_at, f_at;
   always @(posedge line_in) begin
      t_lo = $realtime - f_at;
      t_per = $realtime - r_at;
      r_at = $realtime;
      n_rise = n_rise + 1;
   end
   always @(negedge line_in) begin
      t_hi = $realtime - r_at;
      f_at = $realtime;
   end
endmodule // cepg_cam_model

// ==== bench/tb_cepg_top.sv ====
// Self-checking bench for one generator channel with a camera on line 0.
// Assumes a free-running crystal pin and whole-word register writes.
`timescale 1ns/1ps
module tb_cepg_top;
   realtime tk = 135.634;
   reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   reg xtal = 1'b0, trig = 1'b0, enc = 1'b0, mst = 1'b0, err;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h0, rd;
   wire [31:0] prdata;
   wire pready, pslverr, raw;
   wire [3:0] cc, gp;
   int n_fail = 0, compares = 0, nr, n0;
   realtime th, tl, tp;
   // Address, write data, expected readback, expected error.
   reg [76:0] rows [9] = '{
      {12'h000, 32'hFFFFFFFF, 32'hCFFFFFFF, 1'b0}, {12'h004, 32'hFFFFFFFF, 32'hC0000000, 1'b0},
      {12'h008, 32'hFFFFFFFF, 32'h8FFFFFFF, 1'b0}, {12'h010, 32'h12345678, 32'h12345678, 1'b0},
      {12'h020, 32'hFFFFFFFF, 32'h00000000, 1'b1}, {12'h00C, 32'hFFFFFFFF, 32'h00000000, 1'b0},
      {12'h000, 32'h0, 32'h0, 1'b0}, {12'h004, 32'h0, 32'h0, 1'b0}, {12'h008, 32'h0, 32'h0, 1'b0}};
   cepg_top i_cepg_top (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .xtal_clk_in(xtal), .trigger_in(trig), .encoder_in(enc),
      .master_pulse_in(mst), .raw_pulse_out(raw), .cc_out(cc), .gp_out(gp));
   cepg_cam_model i_cepg_cam_model (
      .line_in(cc[0]), .n_rise(nr), .t_hi(th), .t_lo(tl), .t_per(tp));
   initial forever #10 pclk = ~pclk;
   initial forever #(tk / 2) xtal = ~xtal;
   task conclude;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task apb(input bit w, input [11:0] a, input [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 100);
      if (k == 100) begin
         n_fail++;
         conclude;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task pin(input bit e);
      @(posedge pclk);
      if (e) enc <= 1'b1;
      else trig <= 1'b1;
      repeat (5) @(posedge pclk);
      enc <= 1'b0;
      trig <= 1'b0;
      repeat (10) @(posedge pclk);
   endtask
   initial begin
      repeat (6) @(posedge pclk);
      chk({raw, cc, gp}, 32'h0);
      presetn <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         apb(0, 12'(i * 4), 32'h0);
         chk(rd, 32'h0);
      end
      foreach (rows[i]) begin
         apb(1, rows[i][76:65], rows[i][64:33]);
         chk(err, rows[i][0]);
         apb(0, rows[i][76:65], 32'h0);
         chk(rd, rows[i][32:1]);
      end
      apb(1, 12'h010, 32'h00060003);
      apb(1, 12'h000, 32'h0000000A);
      apb(1, 12'h008, 32'h40000004);
      repeat (300) @(posedge pclk);
      chk(int'(th / tk), 3);
      chk(int'(tp / tk), 10);
      chk(gp, cc);
      apb(1, 12'h004, 32'h40000000);
      repeat (300) @(posedge pclk);
      chk(int'(tl / tk), 3);
      apb(1, 12'h000, 32'h0FFFFFFF);
      apb(1, 12'h008, 32'h4FFFFFFF);
      repeat (60) @(posedge pclk);
      apb(1, 12'h008, 32'h4FFFFFFF);
      apb(0, 12'h00C, 32'h0);
      chk(rd[27:1], 32'h0);
      apb(1, 12'h004, 32'h80000000);
      apb(1, 12'h000, 32'h00000004);
      apb(1, 12'h008, 32'h40000002);
      repeat (9000) @(posedge pclk);
      chk(int'(tp / (tk * 128)), 4);
      apb(1, 12'h004, 32'h0);
      apb(1, 12'h000, 32'h00000000);
      apb(1, 12'h008, 32'h40000006);
      apb(1, 12'h000, 32'h40000000);
      n0 = nr;
      pin(0);
      pin(0);
      repeat (100) @(posedge pclk);
      chk(nr - n0, 1);
      chk(int'(th / tk), 5);
      pin(1);
      repeat (100) @(posedge pclk);
      chk(nr - n0, 1);
      apb(1, 12'h000, 32'hC0000000);
      pin(1);
      repeat (100) @(posedge pclk);
      chk(nr - n0, 2);
      apb(1, 12'h008, 32'h80000000);
      mst <= 1'b1;
      repeat (5) @(posedge pclk);
      chk({raw, cc[0]}, 32'h3);
      mst <= 1'b0;
      repeat (5) @(posedge pclk);
      chk({raw, cc[0]}, 32'h0);
      apb(1, 12'h008, 32'h0);
      conclude;
   end
endmodule // tb_cepg_top
